// ==== pump_regs.sv ====
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Host register bank of the data pump control path
module pump_regs
	import pump_regs_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [9:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_parallel,
	input wire logic i_hit_a,
	input wire logic i_hit_b,
	output logic [15:0] o_rdata,
	output tx_ctl_t o_tx,
	output rx_ctl_t o_rx,
	output det_ctl_t o_det,
	output logic [15:0] o_tone_freq,
	output logic o_irq
);
	logic [15:0] tone_reg; // Control part of tone register
	logic [15:0] buf_reg; // Buffer mode control
	logic [15:0] trn_reg; // Transmit sequence control
	logic [15:0] tonegen_reg; // Tone generator A frequency
	logic [6:0] mode_reg; // Operating mode field
	logic [IRQ_W-1:0] irq_stat_reg; // Sticky detector events
	logic [IRQ_W-1:0] irq_en_reg; // Event enables
	logic [1:0] hit_sync; // Synchronised detector hits
	logic [1:0] hit_prev_reg; // Previous hits for edges
	logic [1:0] hit_rise; // Rising edges of hits
	logic par_sync; // Synchronised transfer select
	tx_ctl_t tx_next; // Decoded transmit controls

	// Write decode used in several processes
	function automatic logic wr_hit(input logic [9:0] a,
		input logic [9:0] idx, input logic w);
		wr_hit = w && (a == idx);
	endfunction

	// Detector hits arrive from the analog side
	pump_sync2 #(.W(2)) u_hit_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_d({i_hit_b, i_hit_a}),
		.o_q(hit_sync)
	);

	// Transfer mode select is a pin
	pump_sync2 #(.W(1)) u_par_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_d(i_parallel),
		.o_q(par_sync)
	);

	// Sequence decode
	pump_tx_seq u_seq (
		.i_trn(trn_reg),
		.i_buf(buf_reg),
		.o_ctl(tx_next)
	);

	// Tone register control bits; flags never stored
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			tone_reg <= TONE_RST;
		else if (wr_hit(i_addr, TONE_IDX, i_wr))
			tone_reg <= i_wdata & TONE_WMASK;
	end

	// Buffer control; host keeps upper byte zero with HDLC
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			buf_reg <= BUF_RST;
		else if (wr_hit(i_addr, BUF_IDX, i_wr))
			buf_reg <= i_wdata;
	end

	// Transmit sequence control
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			trn_reg <= TRN_RST;
		else if (wr_hit(i_addr, TRN_IDX, i_wr))
			trn_reg <= i_wdata;
	end

	// Tone generator frequency, default until reprogrammed
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			tonegen_reg <= TONEGEN_RST;
		else if (wr_hit(i_addr, TONEGEN_IDX, i_wr))
			tonegen_reg <= i_wdata;
	end

	// Operating mode field
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			mode_reg <= MODE_RST;
		else if (wr_hit(i_addr, MODE_IDX, i_wr))
			mode_reg <= i_wdata[6:0];
	end

	// Edge detect on synchronised hits
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			hit_prev_reg <= 2'h0;
		else
			hit_prev_reg <= hit_sync;
	end
	assign hit_rise = hit_sync & ~hit_prev_reg;

	// Sticky status; a new event beats a clear
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			irq_stat_reg <= '0;
		else if (wr_hit(i_addr, IRQ_CLR_IDX, i_wr))
			irq_stat_reg <= (irq_stat_reg & ~i_wdata[IRQ_W-1:0])
				| hit_rise;
		else
			irq_stat_reg <= irq_stat_reg | hit_rise;
	end

	// Interrupt enables
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			irq_en_reg <= '0;
		else if (wr_hit(i_addr, IRQ_EN_IDX, i_wr))
			irq_en_reg <= i_wdata[IRQ_W-1:0];
	end

	// Interrupt level output registered
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			o_irq <= 1'b0;
		else
			o_irq <= |(irq_stat_reg & irq_en_reg);
	end

	// Transmit controls registered
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			o_tx <= '0;
		else
			o_tx <= tx_next;
	end

	// Receive and transfer controls
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			o_rx <= '0;
		else
		begin
			// Serial mode leaves HDLC without effect
			o_rx.hdlc_framing <= par_sync && buf_reg[HDLC_BIT];
			o_rx.descrambler_off <= buf_reg[DSCR_DIS_BIT];
			o_rx.host_marks <= buf_reg[RX_HOLD_BIT];
		end
	end

	// Detector and dial controls
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			o_det <= '0;
		else
		begin
			o_det.cascade <= tone_reg[CASCADE_BIT];
			// Bypass only makes sense when cascaded
			o_det.squarer_bypass <= tone_reg[CASCADE_BIT]
				&& tone_reg[SQR_BYP_BIT];
			o_det.dtmf_dial <= (mode_reg == MODE_DIAL)
				&& tone_reg[TONE_DIAL_BIT];
			o_det.pulse_dial <= (mode_reg == MODE_DIAL)
				&& !tone_reg[TONE_DIAL_BIT];
			o_det.timed <= tone_reg[TIMED_BIT];
		end
	end

	// Tone frequency to generator
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			o_tone_freq <= TONEGEN_RST;
		else
			o_tone_freq <= tonegen_reg;
	end

	// Read data one cycle after strobe; unmapped reads zero
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			o_rdata <= 16'h0000;
		else if (!i_rd)
			o_rdata <= 16'h0000;
		else if (i_addr == TONE_IDX)
		begin
			o_rdata <= tone_reg;
			o_rdata[HIT_A_BIT] <= hit_sync[0];
			o_rdata[HIT_B_BIT] <= hit_sync[1];
		end
		else if (i_addr == BUF_IDX)
			o_rdata <= buf_reg;
		else if (i_addr == TRN_IDX)
			o_rdata <= trn_reg;
		else if (i_addr == TONEGEN_IDX)
			o_rdata <= tonegen_reg;
		else if (i_addr == MODE_IDX)
			o_rdata <= {9'h000, mode_reg};
		else if (i_addr == IRQ_STAT_IDX)
			o_rdata <= {14'h0000, irq_stat_reg};
		else if (i_addr == IRQ_EN_IDX)
			o_rdata <= {14'h0000, irq_en_reg};
		else
			o_rdata <= 16'h0000;
	end

	// Reset restores default tone register
	tone_default_a: assert property (@(posedge i_clk)
		i_rst |=> tone_reg == TONE_RST)
		else $error("tone register not default after reset");
	// Host writes never store detector flags
	flags_unwritten_a: assert property (@(posedge i_clk)
		disable iff (i_rst) tone_reg[15:14] == 2'b00)
		else $error("detector flag stored");
	// HDLC framing only in parallel mode
	hdlc_serial_a: assert property (@(posedge i_clk)
		disable iff (i_rst) o_rx.hdlc_framing |-> $past(par_sync))
		else $error("HDLC framing in serial mode");
	// Hold marks forces marks unless squelched; skip the edge after reset
	tx_hold_a: assert property (@(posedge i_clk)
		disable iff (i_rst) !$past(i_rst) && $past(buf_reg[TX_HOLD_BIT])
		&& !o_tx.squelch |-> o_tx.send_marks && !o_tx.data_mode)
		else $error("tx hold not marks");
	// Data mode follows code five
	data_mode_a: assert property (@(posedge i_clk)
		disable iff (i_rst) o_tx.data_mode |->
		$past(trn_reg[2:0]) == SEQ_DATA)
		else $error("data mode wrong code");
	// Silence on code zero; outputs still cleared on the release edge
	squelch_code_a: assert property (@(posedge i_clk)
		disable iff (i_rst) !$past(i_rst)
		&& $past(trn_reg[2:0]) == SEQ_SILENT |-> o_tx.squelch)
		else $error("no squelch on code zero");
	// Flag A read reflects detector
	flag_read_a: assert property (@(posedge i_clk)
		disable iff (i_rst) i_rd && i_addr == TONE_IDX
		|=> o_rdata[HIT_A_BIT] == $past(hit_sync[0]))
		else $error("flag A read mismatch");
	// Bypass needs cascade
	bypass_cascade_a: assert property (@(posedge i_clk)
		disable iff (i_rst) o_det.squarer_bypass |-> o_det.cascade)
		else $error("bypass without cascade");
	// Host write of the data code while marks are not held
	sequence data_code_write_s;
		i_wr && i_addr == TRN_IDX && i_wdata[2:0] == SEQ_DATA
			&& !buf_reg[TX_HOLD_BIT];
	endsequence
	// Data mode two cycles after the write lands
	data_write_a: assert property (@(posedge i_clk)
		disable iff (i_rst) data_code_write_s
		|=> ##1 o_tx.data_mode)
		else $error("data mode late after code write");
	// Host write of the tone code while marks are not held
	sequence tone_code_write_s;
		i_wr && i_addr == TRN_IDX && i_wdata[2:0] == SEQ_TONE
			&& !buf_reg[TX_HOLD_BIT];
	endsequence
	// Single tone two cycles after the write lands
	tone_write_a: assert property (@(posedge i_clk)
		disable iff (i_rst) tone_code_write_s
		|=> ##1 o_tx.tone_on)
		else $error("tone not sent after code write");
	// Marks on code one
	marks_code_a: assert property (@(posedge i_clk)
		disable iff (i_rst) !$past(i_rst)
		&& $past(trn_reg[2:0]) == SEQ_MARKS |-> o_tx.send_marks)
		else $error("no marks on code one");
	// Spaces on code two unless marks are held
	spaces_code_a: assert property (@(posedge i_clk)
		disable iff (i_rst) !$past(i_rst)
		&& $past(trn_reg[2:0]) == SEQ_SPACES
		&& !$past(buf_reg[TX_HOLD_BIT]) |-> o_tx.send_spaces)
		else $error("no spaces on code two");
	// Scrambler disable follows its bit whatever the code
	scrambler_off_a: assert property (@(posedge i_clk)
		disable iff (i_rst) !$past(i_rst)
		|-> o_tx.scrambler_off == $past(buf_reg[SCR_DIS_BIT]))
		else $error("scrambler disable not applied");
	// HDLC framing in parallel mode with its bit set
	hdlc_parallel_a: assert property (@(posedge i_clk)
		disable iff (i_rst) !$past(i_rst) && $past(par_sync)
		&& $past(buf_reg[HDLC_BIT]) |-> o_rx.hdlc_framing)
		else $error("HDLC framing missing");
	// Descrambler disable follows its bit
	descrambler_off_a: assert property (@(posedge i_clk)
		disable iff (i_rst) !$past(i_rst)
		|-> o_rx.descrambler_off
		== $past(buf_reg[DSCR_DIS_BIT]))
		else $error("descrambler disable not applied");
	// Marks toward the host follow their bit
	host_marks_a: assert property (@(posedge i_clk)
		disable iff (i_rst) !$past(i_rst)
		|-> o_rx.host_marks == $past(buf_reg[RX_HOLD_BIT]))
		else $error("host marks not applied");
	// Flag B read reflects detector B
	flag_b_read_a: assert property (@(posedge i_clk)
		disable iff (i_rst) i_rd && i_addr == TONE_IDX
		|=> o_rdata[HIT_B_BIT] == $past(hit_sync[1]))
		else $error("flag B read mismatch");
	// Cascade control follows its bit
	cascade_follow_a: assert property (@(posedge i_clk)
		disable iff (i_rst) !$past(i_rst)
		|-> o_det.cascade
		== $past(tone_reg[CASCADE_BIT]))
		else $error("cascade not applied");
	// Tone dialing in dial mode with its bit set
	dtmf_dial_a: assert property (@(posedge i_clk)
		disable iff (i_rst) !$past(i_rst)
		&& $past(mode_reg) == MODE_DIAL
		&& $past(tone_reg[TONE_DIAL_BIT]) |-> o_det.dtmf_dial)
		else $error("tone dialing not selected");
	// Timed dialing follows its bit
	timed_follow_a: assert property (@(posedge i_clk)
		disable iff (i_rst) !$past(i_rst)
		|-> o_det.timed == $past(tone_reg[TIMED_BIT]))
		else $error("timed dialing not applied");
	// Tone frequency back to its default after reset
	freq_default_a: assert property (@(posedge i_clk)
		i_rst |=> o_tone_freq == TONEGEN_RST)
		else $error("tone frequency not default after reset");
	// A new detector A event is kept even beside a clear
	event_sticky_a: assert property (@(posedge i_clk)
		disable iff (i_rst) hit_rise[0] |=> irq_stat_reg[0])
		else $error("detector event lost");
	// Interrupt follows an enabled status bit
	irq_level_a: assert property (@(posedge i_clk)
		disable iff (i_rst) (|(irq_stat_reg & irq_en_reg)) |=> o_irq)
		else $error("interrupt not raised");
	// Read data zero outside the read cycle
	rdata_idle_a: assert property (@(posedge i_clk)
		disable iff (i_rst) !i_rd |=> o_rdata == 16'h0000)
		else $error("read data outside read cycle");
endmodule // pump_regs
`default_nettype wire

// ==== pump_regs_pkg.sv ====
// Overview of operation
// - FSK field: 0 silence, 1 marks, 2 spaces
// - Field value 5 starts FSK data mode
// - Value 7 sends one tone, programmable frequency
// - Parallel transfer plus HDLC gives HDLC framing
// - Serial transfer ignores the HDLC bit
// - Bit 3 disables scrambler, overriding sequence
// - Bit 2 forces marks toward remote modem unless the sequence squelches
// - Bit 1 disables the receive descrambler
// - Bit 0 forces marks toward the host
// - Bit 15 shows detector A hit
// - Bit 14 shows detector B hit
// - Bit 13 cascades detectors, result in A
// - Tone dial plus dial mode gives DTMF
// - Bit 5 bypasses squarer when cascaded
// - Bit 4 selects timed dialing, else continuous
// - Reset restores tone register to default
// - Tone frequency defaults to 2225 hertz
`default_nettype none
package pump_regs_pkg;
	// Register indices as printed; byte address is four times index
	localparam logic [9:0] TONE_IDX = 10'h1FC;
	localparam logic [9:0] BUF_IDX = 10'h1FD;
	localparam logic [9:0] TRN_IDX = 10'h1FE;
	localparam logic [9:0] TONEGEN_IDX = 10'h1F0;
	localparam logic [9:0] MODE_IDX = 10'h1F1;
	localparam logic [9:0] IRQ_STAT_IDX = 10'h1F2;
	localparam logic [9:0] IRQ_CLR_IDX = 10'h1F3;
	localparam logic [9:0] IRQ_EN_IDX = 10'h1F4;
	// Reset values
	localparam logic [15:0] TONE_RST = 16'h0080;
	localparam logic [15:0] BUF_RST = 16'h0000;
	localparam logic [15:0] TRN_RST = 16'h0000;
	localparam logic [15:0] TONEGEN_RST = 16'h08B1; // 2225 Hz
	localparam logic [6:0] MODE_RST = 7'h00;
	// Field positions
	localparam int HIT_A_BIT = 15;
	localparam int HIT_B_BIT = 14;
	localparam int CASCADE_BIT = 13;
	localparam int TONE_DIAL_BIT = 7;
	localparam int SQR_BYP_BIT = 5;
	localparam int TIMED_BIT = 4;
	localparam int HDLC_BIT = 7;
	localparam int SCR_DIS_BIT = 3;
	localparam int TX_HOLD_BIT = 2;
	localparam int DSCR_DIS_BIT = 1;
	localparam int RX_HOLD_BIT = 0;
	// Writable mask of tone register: flags and digit excluded
	localparam logic [15:0] TONE_WMASK = 16'h20B0;
	localparam logic [6:0] MODE_DIAL = 7'h03;
	localparam int IRQ_W = 2;
	// Transmit sequence codes
	typedef enum logic [2:0] {
		SEQ_SILENT = 3'b000,
		SEQ_MARKS = 3'b001,
		SEQ_SPACES = 3'b010,
		SEQ_DATA = 3'b101,
		SEQ_TONE = 3'b111
	} tx_seq_t;
	// Transmit path controls
	typedef struct packed {
		logic squelch;
		logic send_marks;
		logic send_spaces;
		logic data_mode;
		logic tone_on;
		logic scrambler_off;
	} tx_ctl_t;
	// Receive and transfer controls
	typedef struct packed {
		logic hdlc_framing;
		logic descrambler_off;
		logic host_marks;
	} rx_ctl_t;
	// Detector and dial controls
	typedef struct packed {
		logic cascade;
		logic squarer_bypass;
		logic dtmf_dial;
		logic pulse_dial;
		logic timed;
	} det_ctl_t;
endpackage
`default_nettype wire

// ==== pump_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for detector hit levels and the transfer mode pin
module pump_sync2
	import pump_regs_pkg::*;
#(
	parameter int W = 2
)(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta_reg; // First stage, read only by o_q
	// Only the second stage is visible downstream
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			meta_reg <= '0;
			o_q <= '0;
		end
		else
		begin
			meta_reg <= i_d;
			o_q <= meta_reg;
		end
	end
endmodule // pump_sync2
`default_nettype wire

// ==== pump_tx_seq.sv ====
`timescale 1ns/1ps
`default_nettype none
// Transmit sequence decoder for FSK modes
module pump_tx_seq
	import pump_regs_pkg::*;
(
	input wire logic [15:0] i_trn,
	input wire logic [15:0] i_buf,
	output tx_ctl_t o_ctl
);
	tx_seq_t seq;
	// Pure decode; registered by the caller
	always_comb
	begin
		seq = tx_seq_t'(i_trn[2:0]);
		o_ctl = '0;
		case (seq)
			SEQ_SILENT: o_ctl.squelch = 1'b1;
			SEQ_MARKS: o_ctl.send_marks = 1'b1;
			SEQ_SPACES: o_ctl.send_spaces = 1'b1;
			SEQ_DATA: o_ctl.data_mode = 1'b1;
			SEQ_TONE: o_ctl.tone_on = 1'b1;
			// Unlisted codes squelch for safety
			default: o_ctl.squelch = 1'b1;
		endcase
		// Hold to marks beats any sequence but silence
		if (i_buf[TX_HOLD_BIT] && !o_ctl.squelch)
		begin
			o_ctl.send_marks = 1'b1;
			o_ctl.send_spaces = 1'b0;
			o_ctl.data_mode = 1'b0;
			o_ctl.tone_on = 1'b0;
		end
		o_ctl.scrambler_off = i_buf[SCR_DIS_BIT];
	end
endmodule // pump_tx_seq
`default_nettype wire

// ==== pump_line_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Line side: tone detectors and transfer pin, off the clock phase
module pump_line_model
(
	input wire logic i_clk,
	input wire logic i_tone_a,
	input wire logic i_tone_b,
	input wire logic i_par,
	output logic o_hit_a,
	output logic o_hit_b,
	output logic o_parallel
);
	initial
	begin
		o_hit_a = 1'b0;
		o_hit_b = 1'b0;
		o_parallel = 1'b0;
	end
	// Late update keeps pins unrelated to the sampling edge
	always @(posedge i_clk)
	begin
		#37;
		o_hit_a = i_tone_a;
		o_hit_b = i_tone_b;
		o_parallel = i_par;
	end
endmodule // pump_line_model
`default_nettype wire

// ==== modem_pump_tx_buffer_tone_regs_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// Host-side bench for the pump register bank
module modem_pump_tx_buffer_tone_regs_tb_top;
	import pump_regs_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [9:0] i_addr = 10'h000;
	logic [15:0] i_wdata = 16'h0000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic tone_a = 1'b0; // Tone present on line
	logic tone_b = 1'b0;
	logic par = 1'b0;
	logic hit_a, hit_b, parallel;
	logic [15:0] o_rdata, o_tone_freq, q;
	tx_ctl_t o_tx;
	rx_ctl_t o_rx;
	det_ctl_t o_det;
	logic o_irq;
	int err_count = 0;
	int compares = 0;
	logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h7};
	logic [5:0] expv [5] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02};
	always #50 i_clk = ~i_clk;
	pump_regs dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_parallel(parallel),
		.i_hit_a(hit_a), .i_hit_b(hit_b), .o_rdata(o_rdata), .o_tx(o_tx),
		.o_rx(o_rx), .o_det(o_det), .o_tone_freq(o_tone_freq),
		.o_irq(o_irq));
	pump_line_model line (.i_clk(i_clk), .i_tone_a(tone_a),
		.i_tone_b(tone_b), .i_par(par), .o_hit_a(hit_a), .o_hit_b(hit_b),
		.o_parallel(parallel));
	// Compare and count
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One-cycle write strobe
	task automatic wr(input logic [9:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [9:0] a, output logic [15:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		d = o_rdata;
	endtask
	// Let register and output stages land; also covers the pin syncs
	task automatic settle();
		repeat (5) @(posedge i_clk);
		@(negedge i_clk);
	endtask
	task automatic t_reset();
		// Outputs need the edge after release to show squelch
		settle();
		check(o_tone_freq, TONEGEN_RST);
		check({10'h0, o_tx}, 16'h0020);
		check({11'h0, o_det}, 16'h0000);
		rd(TONE_IDX, q);
		check(q, 16'h0080);
		rd(BUF_IDX, q);
		check(q, BUF_RST);
		$display("test reset done");
	endtask
	// Every FSK sequence code
	task automatic t_seq();
		for (int k = 0; k < 5; k++)
		begin
			wr(TRN_IDX, {13'h0, codes[k]});
			settle();
			check({10'h0, o_tx}, {10'h0, expv[k]});
		end
		rd(TRN_IDX, q);
		check(q, 16'h0007);
		wr(TONEGEN_IDX, 16'h1234);
		settle();
		check(o_tone_freq, 16'h1234);
		rd(TONEGEN_IDX, q);
		check(q, 16'h1234);
		$display("test sequence done");
	endtask
	// Buffer controls, serial then parallel; upper byte kept zero
	task automatic t_buf();
		wr(BUF_IDX, 16'h008F);
		wr(TRN_IDX, 16'h0005);
		settle();
		check({13'h0, o_rx}, 16'h0003);
		check({15'h0, o_tx.scrambler_off}, 16'h0001);
		check({15'h0, o_tx.send_marks}, 16'h0001);
		par <= 1'b1;
		settle();
		check({13'h0, o_rx}, 16'h0007);
		rd(BUF_IDX, q);
		check(q, 16'h008F);
		wr(BUF_IDX, 16'h0000);
		settle();
		check({15'h0, o_tx.send_marks}, 16'h0000);
		$display("test buffer done");
	endtask
	// Detector and dial controls, flags not writable
	task automatic t_det();
		wr(MODE_IDX, 16'h0003);
		rd(MODE_IDX, q);
		check(q, 16'h0003);
		wr(TONE_IDX, 16'hFFFF);
		settle();
		rd(TONE_IDX, q);
		check(q, TONE_WMASK);
		check({11'h0, o_det}, 16'h001D);
		wr(TONE_IDX, 16'h2030);
		settle();
		check({11'h0, o_det}, 16'h001B);
		wr(TONE_IDX, 16'h0080);
		$display("test detector done");
	endtask
	// Hit flags and the interrupt: raise, mask, clear
	task automatic t_irq();
		wr(IRQ_EN_IDX, 16'h0001);
		tone_a <= 1'b1;
		settle();
		check({15'h0, o_irq}, 16'h0001);
		rd(TONE_IDX, q);
		check(q & 16'hC000, 16'h8000);
		wr(IRQ_CLR_IDX, 16'h0001);
		settle();
		check({15'h0, o_irq}, 16'h0000);
		tone_b <= 1'b1;
		settle();
		check({15'h0, o_irq}, 16'h0000);
		rd(TONE_IDX, q);
		check(q & 16'hC000, 16'hC000);
		rd(IRQ_STAT_IDX, q);
		check(q, 16'h0002);
		wr(IRQ_EN_IDX, 16'h0003);
		settle();
		check({15'h0, o_irq}, 16'h0001);
		rd(IRQ_EN_IDX, q);
		check(q, 16'h0003);
		rd(10'h000, q);
		check(q, 16'h0000);
		$display("test interrupt done");
	endtask
	task automatic stop_test();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Watchdog against a hang
	initial
	begin
		repeat (5000) @(posedge i_clk);
		err_count++;
		stop_test();
	end
	initial
	begin
		repeat (20) @(posedge i_clk);
		i_rst <= 1'b0;
		@(negedge i_clk);
		t_reset();
		t_seq();
		t_buf();
		t_det();
		t_irq();
		stop_test();
	end
endmodule // modem_pump_tx_buffer_tone_regs_tb_top
`default_nettype wire
